// ---- byte_wide_host_port_pinmux.sv ----
`timescale 1ns/100ps
// What this block does
// RL1: Port control word picks host role or GPIO, and bus style, for the whole port.
// RL2: Non-multiplexed host mode: eight data pins are the bidirectional data bus.
// RL3: Multiplexed mode: data pins carry address and data; three pins add bits 8-10.
// RL4: Non-multiplexed mode: three pins are address inputs, one is chip select.
// RL5: Multiplexed mode latches address on an address strobe, polarity default low.
// RL6: Chip select polarity programmable, active low after reset.
// RL7: Single strobe: direction pin plus data strobe of programmable polarity.
// RL8: Dual strobe: separate read and write strobes, programmable polarity.
// RL9: Single request: one request output and an acknowledge input, polarity programmable.
// RL10: Dual request: separate transmit and receive request outputs.
// RL11: Request outputs have programmable polarity and driven or open-drain mode.
// RL12: GPIO mode: each of sixteen pins follows its data direction bit.
// RL13: Host reads receive bytes only after the receive full flag shows data.
// RL14: Host writes transmit bytes only while transmit empty is set.
// RL15: Host changes the vector only while the command bit is clear.
// RL16: Stop state keeps pin setup; inputs ignored, outputs tri-stated.
// RL17: Wait state leaves the pins unchanged.
// RL18: Host strobes, select and acknowledge are synchronised before flags change.
module byte_wide_host_port_pinmux
  import host_port_pkg::*;
(
  input  wire logic                              i_clock,
  input  wire logic                              i_rst,
  input  wire logic [15:0]                       i_port_control,
  input  wire logic [host_port_pkg::PIN_COUNT-1:0] i_data_direction,
  input  wire logic [host_port_pkg::PIN_COUNT-1:0] i_gpio_out,
  output logic      [host_port_pkg::PIN_COUNT-1:0] o_gpio_in,
  input  wire logic                              i_stop,
  input  wire logic [host_port_pkg::PIN_COUNT-1:0] i_pin,
  output logic      [host_port_pkg::PIN_COUNT-1:0] o_pin,
  output logic      [host_port_pkg::PIN_COUNT-1:0] o_pin_oe,
  input  wire logic [host_port_pkg::WORD_W-1:0]    i_core_word,
  input  wire logic                              i_core_word_load,
  output logic                                   o_rx_full_flag,
  output logic                                   o_tx_empty_flag,
  output logic      [host_port_pkg::WORD_W-1:0]    o_core_side_rx_word,
  output logic                                   o_core_side_rx_valid,
  output logic      [host_port_pkg::DATA_W-2:0]    o_command_vector,
  output logic                                   o_command_pending_bit,
  input  wire logic                              i_command_taken
);
  import host_port_pkg::*;

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]           ctl;
    logic [PIN_COUNT-1:0]  s1;
    logic [PIN_COUNT-1:0]  s2;
    logic [PIN_COUNT-1:0]  s3;
    logic [PIN_COUNT-1:0]  pins;
    logic [MUX_ADDR_W-1:0] mux_addr;
    logic                  as_prev;
    logic                  rd_prev;
    logic                  wr_prev;
    logic [WORD_W-1:0]     rx_word;
    logic                  rx_full;
    logic                  tx_empty;
    logic [DATA_W-1:0]     vector;
    fetch_t                fetch;
    logic [WORD_W-1:0]     tx_word;
    logic                  tx_valid;
    logic [PIN_COUNT-1:0]  pin_out;
    logic [PIN_COUNT-1:0]  pin_oe;
    logic [PIN_COUNT-1:0]  gpio_in;
  } port_state_t;

  port_state_t r;
  port_state_t next_r;

  // Turns a pin level into an asserted flag for the chosen polarity.
  function automatic logic asserted(input logic level, input logic active_high);
    asserted = active_high ? level : ~level;
  endfunction

  // -----------------------------------------------------------------
  // Host access decode
  // -----------------------------------------------------------------
  logic                  host_en;
  logic                  muxed;
  logic                  select;
  logic                  as_act;
  logic                  rd_act;
  logic                  wr_act;
  logic                  ack_act;
  logic [REG_ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0]     host_data;
  logic [DATA_W-1:0]     read_byte;
  logic                  store_write;
  logic [REG_ADDR_W-1:0] store_raddr;
  logic [DATA_W-1:0]     store_rdata;
  logic                  rd_done;
  logic                  wr_done;
  logic                  req_single;

  always_comb
  begin
    host_en   = r.ctl[CTL_HOST_EN];
    muxed     = r.ctl[CTL_MUXED];
    host_data = r.pins[PIN_DATA_LSB +: DATA_W];
    // RL6: select polarity
    // RL4: select pin only in direct mode
    select = muxed | asserted(r.pins[PIN_SELECT], r.ctl[CTL_CS_HIGH]);
    // RL5: address strobe polarity
    as_act = muxed & asserted(r.pins[PIN_ADDR0], r.ctl[CTL_AS_HIGH]);
    if (r.ctl[CTL_DUAL_STROBE])
    begin
      // RL8: separate read and write strobes
      rd_act = select & asserted(r.pins[PIN_DIR], r.ctl[CTL_STROBE_HIGH]);
      wr_act = select & asserted(r.pins[PIN_STROBE], r.ctl[CTL_STROBE_HIGH]);
    end
    else
    begin
      // RL7: direction pin qualified by strobe
      rd_act = select & asserted(r.pins[PIN_STROBE], r.ctl[CTL_STROBE_HIGH])
               & r.pins[PIN_DIR];
      wr_act = select & asserted(r.pins[PIN_STROBE], r.ctl[CTL_STROBE_HIGH])
               & ~r.pins[PIN_DIR];
    end
    rd_act  = rd_act & host_en & ~i_stop;
    wr_act  = wr_act & host_en & ~i_stop;
    // RL9: acknowledge polarity
    ack_act = asserted(r.pins[PIN_ACK], r.ctl[CTL_ACK_HIGH]);
    // RL3: latched low address in multiplexed mode
    // RL4: three direct address pins otherwise
    if (muxed)
    begin
      reg_addr = r.mux_addr[REG_ADDR_W-1:0];
    end
    else
    begin
      reg_addr = {r.pins[PIN_ADDR2], r.pins[PIN_ADDR1], r.pins[PIN_ADDR0]};
    end
    // A transfer takes effect on the trailing edge of its strobe.
    // A strobe cut short by the stop state must not complete a transfer.
    rd_done     = r.rd_prev & ~rd_act & ~i_stop;
    wr_done     = r.wr_prev & ~wr_act & ~i_stop;
    store_write = wr_done & (reg_addr >= REG_UPPER);
    case (reg_addr)
      REG_VECTOR: read_byte = r.vector;
      REG_STATUS:
      begin
        read_byte = '0;
        read_byte[STAT_RX_FULL]  = r.rx_full;
        read_byte[STAT_TX_EMPTY] = r.tx_empty;
        read_byte[STAT_CMD]      = r.vector[VEC_CMD_BIT];
      end
      REG_UPPER: read_byte = r.rx_word[2*DATA_W +: DATA_W];
      REG_MID:   read_byte = r.rx_word[DATA_W +: DATA_W];
      REG_LOWER: read_byte = r.rx_word[0 +: DATA_W];
      default:   read_byte = '0;
    endcase
    case (r.fetch)
      FETCH_UPPER: store_raddr = REG_UPPER;
      FETCH_MID:   store_raddr = REG_MID;
      default:     store_raddr = REG_LOWER;
    endcase
  end

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.tx_valid = 1'b0;
    req_single      = 1'b0;

    // RL18: three stage synchroniser, change taken when stages two and three agree
    next_r.s1 = i_pin;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // RL16: inputs ignored while stopped
    if (!i_stop)
    begin
      next_r.pins = (r.s2 & r.s3) | (r.pins & (r.s2 ^ r.s3));
      next_r.ctl  = i_port_control;
    end
    next_r.as_prev = as_act;
    next_r.rd_prev = rd_act;
    next_r.wr_prev = wr_act;

    // RL5: address latched as the strobe releases
    if (r.as_prev && !as_act && !i_stop)
    begin
      next_r.mux_addr = {r.pins[PIN_SELECT], r.pins[PIN_ADDR2], r.pins[PIN_ADDR1], host_data};
    end

    // Vector byte; the command bit is dropped when the core takes it.
    if (i_command_taken)
    begin
      next_r.vector[VEC_CMD_BIT] = 1'b0;
    end
    // RL15: host writes the vector, a new command wins over the clear
    if (wr_done && reg_addr == REG_VECTOR)
    begin
      next_r.vector = host_data;
    end

    // RL13: receive full falls when the host reads the low byte
    if (rd_done && reg_addr == REG_LOWER)
    begin
      next_r.rx_full = 1'b0;
    end
    if (i_core_word_load && !r.rx_full)
    begin
      next_r.rx_word = i_core_word;
      next_r.rx_full = 1'b1;
    end

    // RL14: low byte written starts the move into the core word
    case (r.fetch)
      FETCH_IDLE:
      begin
        if (wr_done && reg_addr == REG_LOWER && r.tx_empty)
        begin
          next_r.tx_empty = 1'b0;
          next_r.fetch    = FETCH_UPPER;
        end
      end
      FETCH_UPPER: next_r.fetch = FETCH_MID;
      FETCH_MID:
      begin
        next_r.tx_word[2*DATA_W +: DATA_W] = store_rdata;
        next_r.fetch = FETCH_LOWER;
      end
      FETCH_LOWER:
      begin
        next_r.tx_word[DATA_W +: DATA_W] = store_rdata;
        next_r.fetch = FETCH_DONE;
      end
      FETCH_DONE:
      begin
        next_r.tx_word[0 +: DATA_W] = store_rdata;
        next_r.tx_valid = 1'b1;
        next_r.tx_empty = 1'b1;
        next_r.fetch    = FETCH_IDLE;
      end
      default: next_r.fetch = FETCH_IDLE;
    endcase

    // RL12: general purpose pins follow the direction word
    next_r.gpio_in = r.pins;
    next_r.pin_out = i_gpio_out;
    next_r.pin_oe  = i_data_direction;

    // RL1: host function overrides the general purpose setup
    if (host_en)
    begin
      next_r.pin_oe  = '0;
      next_r.pin_out = '0;
      // RL2: data pins driven only during a host read
      // RL3: same pins carry the read data in multiplexed mode
      if (rd_act)
      begin
        next_r.pin_oe  = DATA_PIN_MASK;
        next_r.pin_out[PIN_DATA_LSB +: DATA_W] = read_byte;
      end
      if (r.ctl[CTL_DUAL_REQ])
      begin
        // RL10: separate transmit and receive requests
        next_r.pin_out[PIN_REQ] = asserted(r.tx_empty, r.ctl[CTL_REQ_HIGH]);
        next_r.pin_out[PIN_ACK] = asserted(r.rx_full, r.ctl[CTL_REQ_HIGH]);
        next_r.pin_oe[PIN_ACK]  = 1'b1;
      end
      else
      begin
        // RL9: one request, held off while acknowledged
        req_single = (r.rx_full | r.tx_empty) & ~ack_act;
        next_r.pin_out[PIN_REQ] = asserted(req_single, r.ctl[CTL_REQ_HIGH]);
      end
      next_r.pin_oe[PIN_REQ] = 1'b1;
      // RL11: open drain pulls low only
      if (r.ctl[CTL_REQ_OPEN])
      begin
        next_r.pin_oe[PIN_REQ]  = ~next_r.pin_out[PIN_REQ];
        next_r.pin_out[PIN_REQ] = 1'b0;
        if (r.ctl[CTL_DUAL_REQ])
        begin
          next_r.pin_oe[PIN_ACK]  = ~next_r.pin_out[PIN_ACK];
          next_r.pin_out[PIN_ACK] = 1'b0;
        end
      end
    end

    // RL16: outputs tri-stated in stop, setup kept
    // RL17: wait has no effect on the pins
    if (i_stop)
    begin
      next_r.pin_oe  = '0;
      next_r.pin_out = r.pin_out;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      r          <= '0;
      r.ctl      <= CTL_RESET;
      r.tx_empty <= 1'b1;
      r.fetch    <= FETCH_IDLE;
    end
    else
    begin
      r <= next_r;
    end
  end

  // -----------------------------------------------------------------
  // Transmit byte store
  // -----------------------------------------------------------------
  host_byte_store u_store (
    .i_clock      (i_clock),
    .i_rst        (i_rst),
    .i_write      (store_write),
    .i_write_addr (reg_addr),
    .i_write_data (host_data),
    .i_read_addr  (store_raddr),
    .o_read_data  (store_rdata)
  );

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign o_gpio_in             = r.gpio_in;
  assign o_pin                 = r.pin_out;
  assign o_pin_oe              = r.pin_oe;
  assign o_rx_full_flag        = r.rx_full;
  assign o_tx_empty_flag       = r.tx_empty;
  assign o_core_side_rx_word   = r.tx_word;
  assign o_core_side_rx_valid  = r.tx_valid;
  assign o_command_vector      = r.vector[DATA_W-2:0];
  assign o_command_pending_bit = r.vector[VEC_CMD_BIT];

endmodule // byte_wide_host_port_pinmux

// ---- host_bus_model.sv ----
`timescale 1ns/100ps
module host_bus_model
  import host_port_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic [15:0] i_ctl,
  input  wire logic [15:0] i_pin_drv,
  input  wire logic [15:0] i_pin_oe,
  output logic      [15:0] o_level
);
  logic [15:0] drive = 16'h0000;
  logic [15:0] en    = 16'h0000;

  // A line nobody drives shows the inverse of the device's last value.
  always_comb
  begin
    for (int k = 0; k < 16; k++)
      o_level[k] = i_pin_oe[k] ? i_pin_drv[k] : (en[k] ? drive[k] : !i_pin_drv[k]);
  end

  task automatic hold(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  task automatic set_pins(input logic [15:0] v, input logic [15:0] m);
    drive = (drive & ~m) | (v & m);
    en    = en | m;
  endtask

  task automatic set_pin(input int k, input logic v);
    set_pins(16'(v) << k, 16'h0001 << k);
  endtask

  // Every phase is held six clocks, the active strobe eight, so the slow input filter sees it.
  task automatic access(input logic wr, input logic sel, input logic [2:0] addr,
                        input logic [7:0] wdata, output logic [7:0] rdata);
    logic act;
    int   sp;
    act = i_ctl[CTL_STROBE_HIGH];
    sp  = (i_ctl[CTL_DUAL_STROBE] && !wr) ? PIN_DIR : PIN_STROBE;
    set_pin(PIN_STROBE, !act);
    if (i_ctl[CTL_DUAL_STROBE])
      set_pin(PIN_DIR, !act);
    if (i_ctl[CTL_MUXED])
    begin
      set_pins(16'(addr), 16'h26ff);
      set_pin(PIN_ADDR0, i_ctl[CTL_AS_HIGH]);
      hold(6);
      set_pin(PIN_ADDR0, !i_ctl[CTL_AS_HIGH]);
      hold(6);
    end
    else
      set_pins({2'b00, !(sel ^ i_ctl[CTL_CS_HIGH]), 2'b00, addr, 8'h00}, 16'h2700);
    if (!i_ctl[CTL_DUAL_STROBE])
      set_pin(PIN_DIR, !wr);
    drive[7:0] = wdata;
    en[7:0]    = {8{wr}};
    hold(6);
    set_pin(sp, act);
    hold(8);
    rdata = o_level[7:0];
    set_pin(sp, !act);
    hold(6);
    en[7:0] = 8'h00;
    if (!i_ctl[CTL_MUXED])
      set_pin(PIN_SELECT, !i_ctl[CTL_CS_HIGH]);
    hold(6);
  endtask
endmodule // host_bus_model

// ---- host_byte_store.sv ----
`timescale 1ns/100ps
module host_byte_store
  import host_port_pkg::*;
(
  input  wire logic                          i_clock,
  input  wire logic                          i_rst,
  input  wire logic                          i_write,
  input  wire logic [host_port_pkg::REG_ADDR_W-1:0] i_write_addr,
  input  wire logic [host_port_pkg::DATA_W-1:0]     i_write_data,
  input  wire logic [host_port_pkg::REG_ADDR_W-1:0] i_read_addr,
  output logic      [host_port_pkg::DATA_W-1:0]     o_read_data
);
  import host_port_pkg::*;

  typedef struct packed {
    logic [STORE_DEPTH-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0]                  rdata;
  } store_t;

  store_t r;
  store_t next_r;

  always_comb
  begin
    next_r = r;
    next_r.rdata = r.mem[i_read_addr];
    if (i_write)
    begin
      next_r.mem[i_write_addr] = i_write_data;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_read_data = r.rdata;

endmodule // host_byte_store

// ---- host_port_chk.sv ----
`timescale 1ns/100ps
module host_port_chk
  import host_port_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic [15:0] i_port_control,
  input wire logic        i_stop,
  input wire logic [15:0] i_data_direction,
  input wire logic [15:0] i_pin,
  input wire logic [15:0] o_pin,
  input wire logic [15:0] o_pin_oe,
  input wire logic        o_rx_full_flag,
  input wire logic        o_tx_empty_flag,
  input wire logic        o_core_side_rx_valid,
  input wire logic        i_core_word_load,
  input wire logic        i_command_taken,
  input wire logic        o_command_pending_bit
);
  default clocking dclk @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic [15:0] c;
  logic        host;
  logic        idle_rd;
  assign c = i_port_control;
  assign host = c[CTL_HOST_EN] && !i_stop;
  assign idle_rd = host && (i_pin[PIN_STROBE] != c[CTL_STROBE_HIGH])
    && (!c[CTL_DUAL_STROBE] || (i_pin[PIN_DIR] != c[CTL_STROBE_HIGH]));

  // A word move holds empty low for four clocks, then hands the word over.
  sequence move_s;
    !o_tx_empty_flag[*4] ##1 (o_core_side_rx_valid && o_tx_empty_flag);
  endsequence

  reset_state_a: assert property (disable iff (1'b0) i_rst |=>
    o_pin_oe == 16'h0000 && o_tx_empty_flag && !o_rx_full_flag)
    else $error("reset state wrong");
  stop_off_a: assert property (i_stop |=> o_pin_oe == 16'h0000)
    else $error("pins driven in stop");
  gpio_follow_a: assert property ((!c[CTL_HOST_EN] && !i_stop)[*3] |=>
    o_pin_oe == $past(i_data_direction))
    else $error("gpio direction not followed");
  load_full_a: assert property (i_core_word_load && !o_rx_full_flag |=> o_rx_full_flag)
    else $error("receive full not set");
  word_move_a: assert property ($fell(o_tx_empty_flag) |-> move_s)
    else $error("word move timing wrong");
  cmd_clear_a: assert property (i_command_taken |=> !o_command_pending_bit)
    else $error("command bit not cleared");
  read_idle_a: assert property ((idle_rd && $stable(c))[*6] |-> o_pin_oe[7:0] == 8'h00)
    else $error("data driven without read");
  dual_req_a: assert property ((host && c[CTL_DUAL_REQ] && !c[CTL_REQ_OPEN]
    && o_tx_empty_flag && $stable(c))[*4] |-> o_pin_oe[PIN_REQ] && o_pin[PIN_REQ] == c[CTL_REQ_HIGH])
    else $error("transmit request wrong");
  open_drain_a: assert property ((host && c[CTL_REQ_OPEN] && $stable(c))[*4] |->
    !(o_pin_oe[PIN_REQ] && o_pin[PIN_REQ]))
    else $error("open drain drives high");
  ack_mask_a: assert property ((host && !c[CTL_DUAL_REQ] && !c[CTL_REQ_OPEN] && $stable(c)
    && i_pin[PIN_ACK] == c[CTL_ACK_HIGH])[*6] |-> o_pin[PIN_REQ] != c[CTL_REQ_HIGH])
    else $error("request not masked by ack");
endmodule // host_port_chk

// ---- host_port_pkg.sv ----
package host_port_pkg;

  // ---------------------------------------------------------------
  // Widths and sizes
  // ---------------------------------------------------------------
  localparam int PIN_COUNT  = 16;
  localparam int DATA_W     = 8;
  localparam int WORD_W     = 24;
  localparam int REG_ADDR_W = 3;
  localparam int MUX_ADDR_W = 11;
  localparam int STORE_DEPTH = 8;

  // ---------------------------------------------------------------
  // Port control word fields
  // ---------------------------------------------------------------
  localparam int CTL_HOST_EN     = 0;
  localparam int CTL_MUXED       = 1;
  localparam int CTL_DUAL_STROBE = 2;
  localparam int CTL_DUAL_REQ    = 3;
  localparam int CTL_AS_HIGH     = 4;
  localparam int CTL_CS_HIGH     = 5;
  localparam int CTL_STROBE_HIGH = 6;
  localparam int CTL_REQ_HIGH    = 7;
  localparam int CTL_ACK_HIGH    = 8;
  localparam int CTL_REQ_OPEN    = 9;
  localparam logic [15:0] CTL_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // Pin positions
  // ---------------------------------------------------------------
  localparam int PIN_DATA_LSB = 0;
  localparam int PIN_ADDR0    = 8;
  localparam int PIN_ADDR1    = 9;
  localparam int PIN_ADDR2    = 10;
  localparam int PIN_DIR      = 11;
  localparam int PIN_STROBE   = 12;
  localparam int PIN_SELECT   = 13;
  localparam int PIN_REQ      = 14;
  localparam int PIN_ACK      = 15;
  localparam logic [15:0] DATA_PIN_MASK = 16'h00ff;

  // ---------------------------------------------------------------
  // Host visible byte registers and status bits
  // ---------------------------------------------------------------
  localparam logic [2:0] REG_VECTOR = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_UPPER  = 3'h5;
  localparam logic [2:0] REG_MID    = 3'h6;
  localparam logic [2:0] REG_LOWER  = 3'h7;
  localparam int STAT_RX_FULL  = 0;
  localparam int STAT_TX_EMPTY = 1;
  localparam int STAT_CMD      = 2;
  localparam int VEC_CMD_BIT   = 7;

  typedef enum logic [2:0] {
    FETCH_IDLE,
    FETCH_UPPER,
    FETCH_MID,
    FETCH_LOWER,
    FETCH_DONE
  } fetch_t;

endpackage

// ---- testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import host_port_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic [15:0] i_port_control = 16'h0000;
  logic [15:0] i_data_direction = 16'h0000;
  logic [15:0] i_gpio_out = 16'h0000;
  logic        i_stop = 1'b0;
  logic [23:0] i_core_word = 24'h000000;
  logic        i_core_word_load = 1'b0;
  logic        i_command_taken = 1'b0;
  logic [15:0] i_pin, o_gpio_in, o_pin, o_pin_oe;
  logic [23:0] o_core_side_rx_word;
  logic [6:0]  o_command_vector;
  logic        o_rx_full_flag, o_tx_empty_flag, o_core_side_rx_valid, o_command_pending_bit;
  logic [23:0] got_word = 24'h000000;
  int          got_cnt = 0;
  int          num_errors = 0;
  int          checked = 0;
  logic [15:0] mode_ctl [6] = '{16'h0001, 16'h0005, 16'h0041, 16'h0021, 16'h0003, 16'h0013};
  logic [15:0] req_ctl [5] = '{16'h0009, 16'h0089, 16'h0209, 16'h0201, 16'h0101};
  logic [3:0]  req_exp [5] = '{4'he, 4'hd, 4'h4, 4'h4, 4'h5};

  always #4 i_clock = ~i_clock;

  byte_wide_host_port_pinmux dut_u (.i_clock(i_clock), .i_rst(i_rst),
    .i_port_control(i_port_control), .i_data_direction(i_data_direction),
    .i_gpio_out(i_gpio_out), .o_gpio_in(o_gpio_in), .i_stop(i_stop), .i_pin(i_pin),
    .o_pin(o_pin), .o_pin_oe(o_pin_oe), .i_core_word(i_core_word),
    .i_core_word_load(i_core_word_load), .o_rx_full_flag(o_rx_full_flag),
    .o_tx_empty_flag(o_tx_empty_flag), .o_core_side_rx_word(o_core_side_rx_word),
    .o_core_side_rx_valid(o_core_side_rx_valid), .o_command_vector(o_command_vector),
    .o_command_pending_bit(o_command_pending_bit), .i_command_taken(i_command_taken));

  host_bus_model host_u (.i_clock(i_clock), .i_ctl(i_port_control), .i_pin_drv(o_pin),
    .i_pin_oe(o_pin_oe), .o_level(i_pin));

  always @(posedge i_clock)
    if (o_core_side_rx_valid)
    begin
      got_word <= o_core_side_rx_word;
      got_cnt  <= got_cnt + 1;
    end

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic sel = 1'b1);
    logic [7:0] r;
    host_u.access(1'b1, sel, a, d, r);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] r;
    host_u.access(1'b0, 1'b1, a, 8'h00, r);
    check(24'(r), 24'(e));
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // The whole sequence needs about 800 clocks; the limit allows far more.
  initial
  begin
    #200000;
    num_errors++;
    stop_test();
  end

  initial
  begin
    repeat (12) @(negedge i_clock);
    i_rst = 1'b0;
    @(negedge i_clock);
    check(24'({o_pin_oe, o_tx_empty_flag, o_rx_full_flag}), 24'h000002);
    i_data_direction = 16'h0f0f;
    i_gpio_out = 16'h0505;
    host_u.set_pins(16'ha0a0, 16'hf0f0);
    repeat (6) @(negedge i_clock);
    check(24'(o_pin_oe), 24'h000f0f);
    check(24'(o_pin & 16'h0f0f), 24'h000505);
    check(24'(o_gpio_in & 16'hf0f0), 24'h00a0a0);
    // A pin glitch lasting one clock must not get past the input filter.
    host_u.set_pins(16'h0000, 16'h8000);
    @(negedge i_clock);
    host_u.set_pins(16'h8000, 16'h8000);
    repeat (6) @(negedge i_clock);
    check(24'(o_gpio_in & 16'hf0f0), 24'h00a0a0);
    $display("test gpio done");
    host_u.set_pins(16'hb800, 16'hff00);
    i_port_control = 16'h0001;
    repeat (6) @(negedge i_clock);
    wr(REG_UPPER, 8'h11);
    wr(REG_MID, 8'h22);
    wr(REG_LOWER, 8'h33);
    check(got_word, 24'h112233);
    check(24'(got_cnt), 24'h000001);
    rd(REG_STATUS, 8'h02);
    $display("test word write done");
    wr(REG_VECTOR, 8'h85, 1'b0);
    check(24'({o_command_pending_bit, o_command_vector}), 24'h000000);
    wr(REG_VECTOR, 8'h85);
    check(24'({o_command_pending_bit, o_command_vector}), 24'h000085);
    rd(REG_STATUS, 8'h06);
    i_command_taken = 1'b1;
    @(negedge i_clock);
    i_command_taken = 1'b0;
    check(24'(o_command_pending_bit), 24'h000000);
    check(24'({o_pin_oe[PIN_REQ], o_pin[PIN_REQ]}), 24'h000002);
    host_u.set_pin(PIN_ACK, 1'b0);
    repeat (8) @(negedge i_clock);
    check(24'({o_pin_oe[PIN_REQ], o_pin[PIN_REQ]}), 24'h000003);
    host_u.set_pin(PIN_ACK, 1'b1);
    $display("test vector done");
    i_core_word = 24'habcdef;
    i_core_word_load = 1'b1;
    @(negedge i_clock);
    i_core_word_load = 1'b0;
    check(24'(o_rx_full_flag), 24'h000001);
    rd(REG_UPPER, 8'hab);
    rd(REG_MID, 8'hcd);
    rd(REG_LOWER, 8'hef);
    check(24'(o_rx_full_flag), 24'h000000);
    $display("test word read done");
    foreach (mode_ctl[i])
    begin
      i_port_control = mode_ctl[i];
      repeat (8) @(negedge i_clock);
      wr(REG_VECTOR, 8'h10 + 8'(i));
      check(24'(o_command_vector), 24'h000010 + 24'(i));
      rd(REG_VECTOR, 8'h10 + 8'(i));
    end
    $display("test bus modes done");
    foreach (req_ctl[i])
    begin
      i_port_control = req_ctl[i];
      repeat (8) @(negedge i_clock);
      check(24'({o_pin_oe[15:14], o_pin[15:14] & o_pin_oe[15:14]}), 24'(req_exp[i]));
    end
    $display("test requests done");
    i_port_control = 16'h0001;
    i_stop = 1'b1;
    repeat (4) @(negedge i_clock);
    check(24'(o_pin_oe), 24'h000000);
    wr(REG_VECTOR, 8'h33);
    check(24'(o_command_vector), 24'h000015);
    i_stop = 1'b0;
    $display("test stop done");
    stop_test();
  end
endmodule // testbench

bind byte_wide_host_port_pinmux host_port_chk chk_u (.i_clock(i_clock), .i_rst(i_rst),
  .i_port_control(i_port_control), .i_stop(i_stop), .i_data_direction(i_data_direction),
  .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe), .o_rx_full_flag(o_rx_full_flag),
  .o_tx_empty_flag(o_tx_empty_flag), .o_core_side_rx_valid(o_core_side_rx_valid),
  .i_core_word_load(i_core_word_load), .i_command_taken(i_command_taken),
  .o_command_pending_bit(o_command_pending_bit));
